// ==== logic/aef_regs.vh ====
// register map, field positions and command codes of the axis event flag block
`ifndef AEF_REGS_VH
`define AEF_REGS_VH

// direct addresses
`define AEF_ADDR_EVENT_FLAG   8'h30
`define AEF_ADDR_EXT_STATE    8'h38

// indirect commands
`define AEF_CMD_RD_EVENT_FLAG 8'hF3
`define AEF_CMD_WR_EVENT_FLAG 8'hB3
`define AEF_CMD_RD_EXT_STATE  8'hF1
`define AEF_CMD_RD_ERR_FLAG   8'hF2

// widths
`define AEF_FLAG_W            20
`define AEF_DATA_W            32
`define AEF_PIN_W             15

// event flag bits
`define AEF_EV_STOP           0
`define AEF_EV_SHIFT          1
`define AEF_EV_MPRE           2
`define AEF_EV_CPRE           3
`define AEF_EV_ACC_ST         4
`define AEF_EV_ACC_END        5
`define AEF_EV_DEC_ST         6
`define AEF_EV_DEC_END        7
`define AEF_EV_CMP_LO         8
`define AEF_EV_CMP_HI         12
`define AEF_EV_CLR            13
`define AEF_EV_LATCH          14
`define AEF_EV_ORIGIN         15
`define AEF_EV_SLOW           16
`define AEF_EV_DRP            17
`define AEF_EV_DRM            18
`define AEF_EV_GO             19

// synchronised pin vector positions
`define AEF_PIN_CGO           0
`define AEF_PIN_LGO           1
`define AEF_PIN_HALT          2
`define AEF_PIN_EMERG         3
`define AEF_PIN_PCS           4
`define AEF_PIN_EZ            5
`define AEF_PIN_DRP           6
`define AEF_PIN_DRM           7
`define AEF_PIN_CLR           8
`define AEF_PIN_LTC           9
`define AEF_PIN_ORG           10
`define AEF_PIN_SDP           11
`define AEF_PIN_SDM           12
`define AEF_PIN_INP           13
`define AEF_PIN_PEN           14

// selection codes
`define AEF_LTM_LATCH_PIN     2'h0
`define AEF_LTM_ORIGIN        2'h1
`define AEF_GOSEL_COMMON      1'h0
`define AEF_CLR_NONE          4'h0

// startup settle: synchroniser depth plus one history stage
`define AEF_PRIME_DONE        2'h3

`endif

// ==== logic/aef_sync2.v ====
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module aef_sync2 #(
	parameter WIDTH = 15
) (
	input  wire             sys_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	// first stage is read only by the second
	reg [WIDTH-1:0] meta_reg;

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// ==== logic/aef_flags_status.v ====
// axis event flag register and extension status register with host access
`timescale 1ns/1ps
`default_nettype none
`include "aef_regs.vh"

module aef_flags_status (
	input  wire                   sys_clk,
	input  wire                   rst_n,
	// direct host access
	input  wire [7:0]             host_addr,
	input  wire                   host_rd,
	input  wire                   host_wr,
	input  wire [`AEF_DATA_W-1:0] host_wdata,
	// indirect command access
	input  wire                   cmd_wr,
	input  wire [7:0]             cmd_code,
	input  wire [`AEF_DATA_W-1:0] cmd_wdata,
	output reg  [`AEF_DATA_W-1:0] host_rdata,
	output reg                    host_rvalid,
	output reg                    int_n,
	output reg                    err_read_clear,
	// configuration
	input  wire [`AEF_FLAG_W-1:0] event_enable_reg,
	input  wire                   read_clear_inhibit,
	input  wire                   go_source_sel,
	input  wire [1:0]             latch_timing_sel,
	input  wire [3:0]             clear_target_sel,
	input  wire                   go_pol,
	input  wire                   erc_pol,
	input  wire                   ez_pol,
	input  wire                   dir_pol,
	input  wire                   clr_pol,
	input  wire                   ltc_pol,
	input  wire                   sd_pol,
	input  wire                   inp_pol,
	// motion engine, same clock
	input  wire                   stop_normal_evt,
	input  wire                   prereg_shift_evt,
	input  wire                   motion_prereg_full,
	input  wire                   compare_prereg_full,
	input  wire                   accelerating_flag,
	input  wire                   decelerating_flag,
	input  wire [4:0]             cmp_match,
	input  wire                   counter_cleared_evt,
	input  wire                   count_latched_evt,
	input  wire [3:0]             operating_state,
	input  wire                   motion_sense_bit,
	input  wire                   deviation_reset_output,
	input  wire [1:0]             compare_queue_depth,
	input  wire [1:0]             motion_queue_depth,
	input  wire                   slowdown_latch_release,
	// pins, asynchronous
	input  wire                   common_go_input_n,
	input  wire                   local_go_input,
	input  wire                   common_halt_input_n,
	input  wire                   common_emergency_input_n,
	input  wire                   position_compare_pin,
	input  wire                   encoder_index,
	input  wire                   manual_direction_input_p,
	input  wire                   manual_direction_input_m,
	input  wire                   counter_clear_input,
	input  wire                   latch_trigger,
	input  wire                   origin_sensor,
	input  wire                   slow_down_input_p,
	input  wire                   slow_down_input_m,
	input  wire                   in_position_signal,
	input  wire                   pulser_enable_pin
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// pol high means the pin is active high
	function is_on;
		input level;
		input pol;
		is_on = ~(level ^ pol);
	endfunction
	function rise;
		input now;
		input was;
		rise = now & ~was;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisation and polarity
	// ------------------------------------------------------------
	wire [`AEF_PIN_W-1:0] pin_sync;
	wire [`AEF_PIN_W-1:0] pin_raw = {pulser_enable_pin, in_position_signal, slow_down_input_m,
		slow_down_input_p, origin_sensor, latch_trigger, counter_clear_input,
		manual_direction_input_m, manual_direction_input_p, encoder_index,
		position_compare_pin, common_emergency_input_n, common_halt_input_n,
		local_go_input, common_go_input_n};

	aef_sync2 #(
		.WIDTH    (`AEF_PIN_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (pin_raw),
		.sync_out (pin_sync)
	);
	wire cgo_on, lgo_on, go_on, halt_on, emerg_on, pcs_on, erc_on, ez_on, drp_on;
	wire drm_on, clr_on, ltc_on, org_on, sdp_on, sdm_on, inp_on, pen_high, sd_dir_on;
	// common inputs are fixed active low
	assign cgo_on    = ~pin_sync[`AEF_PIN_CGO];
	assign halt_on   = ~pin_sync[`AEF_PIN_HALT];
	assign emerg_on  = ~pin_sync[`AEF_PIN_EMERG];
	assign lgo_on    = is_on(pin_sync[`AEF_PIN_LGO], go_pol);
	assign go_on     = (go_source_sel == `AEF_GOSEL_COMMON) ? cgo_on : lgo_on;
	assign pcs_on    = is_on(pin_sync[`AEF_PIN_PCS], go_pol);
	assign erc_on    = is_on(deviation_reset_output, erc_pol);
	assign ez_on     = is_on(pin_sync[`AEF_PIN_EZ], ez_pol);
	assign drp_on    = is_on(pin_sync[`AEF_PIN_DRP], dir_pol);
	assign drm_on    = is_on(pin_sync[`AEF_PIN_DRM], dir_pol);
	assign clr_on    = is_on(pin_sync[`AEF_PIN_CLR], clr_pol);
	assign ltc_on    = is_on(pin_sync[`AEF_PIN_LTC], ltc_pol);
	assign org_on    = pin_sync[`AEF_PIN_ORG];
	assign sdp_on    = is_on(pin_sync[`AEF_PIN_SDP], sd_pol);
	assign sdm_on    = is_on(pin_sync[`AEF_PIN_SDM], sd_pol);
	assign inp_on    = is_on(pin_sync[`AEF_PIN_INP], inp_pol);
	assign pen_high  = pin_sync[`AEF_PIN_PEN];
	assign sd_dir_on = motion_sense_bit ? sdm_on : sdp_on;

	// ------------------------------------------------------------
	// history for edge detection
	// ------------------------------------------------------------
	reg       mfull_reg, cfull_reg, acc_reg, dec_reg, drp_reg, drm_reg, sd_dir_reg, go_reg;
	reg [4:0] cmp_reg;
	reg [1:0] prime_reg;
	// history is meaningless until the synchroniser has filled
	wire      primed = (prime_reg == `AEF_PRIME_DONE);

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			mfull_reg  <= 1'b0;
			cfull_reg  <= 1'b0;
			acc_reg    <= 1'b0;
			dec_reg    <= 1'b0;
			cmp_reg    <= 5'h00;
			drp_reg    <= 1'b0;
			drm_reg    <= 1'b0;
			sd_dir_reg <= 1'b0;
			go_reg     <= 1'b0;
			prime_reg  <= 2'h0;
		end
		else
		begin
			mfull_reg  <= motion_prereg_full;
			cfull_reg  <= compare_prereg_full;
			acc_reg    <= accelerating_flag;
			dec_reg    <= decelerating_flag;
			cmp_reg    <= cmp_match;
			drp_reg    <= drp_on;
			drm_reg    <= drm_on;
			sd_dir_reg <= sd_dir_on;
			go_reg     <= go_on;
			if (!primed)
				prime_reg <= prime_reg + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// event conditions
	// ------------------------------------------------------------
	reg [`AEF_FLAG_W-1:0] cond;
	always @*
	begin
		cond = {`AEF_FLAG_W{1'b0}};
		cond[`AEF_EV_STOP]    = stop_normal_evt;
		cond[`AEF_EV_SHIFT]   = prereg_shift_evt;
		cond[`AEF_EV_MPRE]    = rise(mfull_reg, motion_prereg_full);
		cond[`AEF_EV_CPRE]    = rise(cfull_reg, compare_prereg_full);
		cond[`AEF_EV_ACC_ST]  = rise(accelerating_flag, acc_reg);
		cond[`AEF_EV_ACC_END] = rise(acc_reg, accelerating_flag);
		cond[`AEF_EV_DEC_ST]  = rise(decelerating_flag, dec_reg);
		cond[`AEF_EV_DEC_END] = rise(dec_reg, decelerating_flag);
		cond[`AEF_EV_CMP_HI:`AEF_EV_CMP_LO] = cmp_match & ~cmp_reg;
		cond[`AEF_EV_CLR]     = counter_cleared_evt & clr_on &
			(clear_target_sel != `AEF_CLR_NONE);
		cond[`AEF_EV_LATCH]   = count_latched_evt & ltc_on &
			(latch_timing_sel == `AEF_LTM_LATCH_PIN);
		cond[`AEF_EV_ORIGIN]  = count_latched_evt & org_on &
			(latch_timing_sel == `AEF_LTM_ORIGIN);
		cond[`AEF_EV_SLOW]    = primed & rise(sd_dir_on, sd_dir_reg);
		// manual direction change, blocked by pulser enable
		cond[`AEF_EV_DRP]     = primed & ~pen_high & (drp_on ^ drp_reg);
		cond[`AEF_EV_DRM]     = primed & ~pen_high & (drm_on ^ drm_reg);
		cond[`AEF_EV_GO]      = primed & rise(go_on, go_reg);
	end

	// ------------------------------------------------------------
	// host decode
	// ------------------------------------------------------------
	wire dir_wr_flag, cmd_wr_flag, cmd_rd_flag, cmd_rd_state, dir_rd_flag, dir_rd_state;
	wire rd_clear, host_rd_err_cmd;

	assign dir_wr_flag  = host_wr & (host_addr == `AEF_ADDR_EVENT_FLAG);
	assign dir_rd_flag  = host_rd & (host_addr == `AEF_ADDR_EVENT_FLAG);
	assign dir_rd_state = host_rd & (host_addr == `AEF_ADDR_EXT_STATE);
	assign cmd_wr_flag  = cmd_wr & (cmd_code == `AEF_CMD_WR_EVENT_FLAG);
	assign cmd_rd_flag  = cmd_wr & (cmd_code == `AEF_CMD_RD_EVENT_FLAG);
	assign cmd_rd_state = cmd_wr & (cmd_code == `AEF_CMD_RD_EXT_STATE);
	// read command clears after returning value
	assign rd_clear     = cmd_rd_flag & ~read_clear_inhibit;
	// error register lives elsewhere; only its read command is decoded here
	assign host_rd_err_cmd = cmd_wr & (cmd_code == `AEF_CMD_RD_ERR_FLAG);

	// ------------------------------------------------------------
	// event flag register
	// ------------------------------------------------------------
	reg  [`AEF_FLAG_W-1:0] event_flag_reg, event_flag_next, w1c_mask;
	always @*
	begin
		w1c_mask = {`AEF_FLAG_W{1'b0}};
		// ones clear, zeros keep; upper bits dropped
		if (dir_wr_flag)
			w1c_mask = w1c_mask | host_wdata[`AEF_FLAG_W-1:0];
		if (cmd_wr_flag)
			w1c_mask = w1c_mask | cmd_wdata[`AEF_FLAG_W-1:0];
		if (rd_clear)
			w1c_mask = {`AEF_FLAG_W{1'b1}};
		// only enabled conditions set; a set beats a same-cycle clear
		event_flag_next = (event_flag_reg & ~w1c_mask) | (cond & event_enable_reg);
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			event_flag_reg <= {`AEF_FLAG_W{1'b0}};
			int_n          <= 1'b1;
			err_read_clear <= 1'b0;
		end
		else
		begin
			event_flag_reg <= event_flag_next;
			int_n          <= ~(|event_flag_next);
			// same inhibit governs error register read-clear
			err_read_clear <= host_rd_err_cmd & ~read_clear_inhibit;
		end
	end

	// ------------------------------------------------------------
	// slow-down latches
	// ------------------------------------------------------------
	reg psd_latched_reg, msd_latched_reg;
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			psd_latched_reg <= 1'b0;
			msd_latched_reg <= 1'b0;
		end
		else
		begin
			// latch on input, release from engine; latch wins
			psd_latched_reg <= sdp_on | (psd_latched_reg & ~slowdown_latch_release);
			msd_latched_reg <= sdm_on | (msd_latched_reg & ~slowdown_latch_release);
		end
	end

	// ------------------------------------------------------------
	// extension status
	// ------------------------------------------------------------
	// engine resolves the all-ones catch-all state itself
	// signal levels; direction status not gated by pulser enable
	// queue depth fields; upper byte zero
	wire [`AEF_DATA_W-1:0] ext_state = {8'h00, msd_latched_reg, psd_latched_reg,
		motion_queue_depth, compare_queue_depth, sdm_on, inp_on,
		sdp_on, ltc_on, clr_on, drm_on, drp_on, ez_on, erc_on, pcs_on,
		emerg_on, halt_on, go_on, motion_sense_bit, operating_state};

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			host_rdata  <= {`AEF_DATA_W{1'b0}};
			host_rvalid <= 1'b0;
		end
		else
		begin
			host_rvalid <= host_rd | cmd_rd_flag | cmd_rd_state;
			if (dir_rd_flag | cmd_rd_flag)
				host_rdata <= {{(`AEF_DATA_W-`AEF_FLAG_W){1'b0}}, event_flag_reg};
			else if (dir_rd_state | cmd_rd_state)
				host_rdata <= ext_state;
			else if (host_rd)
				host_rdata <= {`AEF_DATA_W{1'b0}};
		end
	end

endmodule

`default_nettype wire

// ==== logic/_unused_end.v ====
// intentionally empty source unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/aef_host.sv ====
// host processor model for direct and indirect register access
`timescale 1ns/1ps
`default_nettype none
module aef_host (
	input wire logic		sys_clk,
	input wire logic [31:0]	host_rdata,
	input wire logic		host_rvalid,
	output logic [7:0]		host_addr,
	output logic			host_rd,
	output logic			host_wr,
	output logic [31:0]		host_wdata,
	output logic			cmd_wr,
	output logic [7:0]		cmd_code,
	output logic [31:0]		cmd_wdata
);
	initial
	begin
		{host_rd, host_wr, cmd_wr} = 3'h0;
		{host_addr, cmd_code} = 16'h0000;
		{host_wdata, cmd_wdata} = 64'h0;
	end
	// kind 0 direct read, 1 direct write, 2 command; q is unknown without an answer
	task automatic xfer(input int kind, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge sys_clk);
		host_addr = a;
		cmd_code = a;
		host_wdata = d;
		cmd_wdata = d;
		host_rd = (kind == 0);
		// ones in the data clear flags
		host_wr = (kind == 1);
		cmd_wr = (kind == 2);
		@(negedge sys_clk);
		q = (host_rvalid === 1'b1) ? host_rdata : 32'hX;
		{host_rd, host_wr, cmd_wr} = 3'h0;
		// idle lines change so a stale value cannot pass
		host_wdata = ~d;
		cmd_wdata = ~d;
		host_addr = ~a;
		cmd_code = ~a;
	endtask
endmodule
`default_nettype wire

// ==== tb/aef_chk.sv ====
// port-level assertions for the event flag and status block
`timescale 1ns/1ps
`default_nettype none
`include "aef_regs.vh"
module aef_chk (
	input wire logic		sys_clk,
	input wire logic		rst_n,
	input wire logic [7:0]	host_addr,
	input wire logic		host_rd,
	input wire logic		host_wr,
	input wire logic [31:0]	host_wdata,
	input wire logic		cmd_wr,
	input wire logic [7:0]	cmd_code,
	input wire logic [31:0]	host_rdata,
	input wire logic		host_rvalid,
	input wire logic		int_n,
	input wire logic [19:0]	event_enable_reg,
	input wire logic		read_clear_inhibit,
	input wire logic		stop_normal_evt,
	input wire logic [3:0]	operating_state,
	input wire logic		motion_sense_bit,
	input wire logic [1:0]	motion_queue_depth
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic	wr_flags;
	logic	rd_flags_cmd;
	assign wr_flags = host_wr && host_addr == `AEF_ADDR_EVENT_FLAG && !cmd_wr;
	assign rd_flags_cmd = cmd_wr && cmd_code == `AEF_CMD_RD_EVENT_FLAG && !host_wr;
	a_stop_sets_int: assert property (stop_normal_evt && event_enable_reg[0] |=> !int_n)
		else $error("stop event did not raise interrupt");
	a_masked_quiet: assert property (event_enable_reg == 20'h00000 && int_n |=> int_n)
		else $error("interrupt without enabled condition");
	a_int_rise_why: assert property ($rose(int_n) |-> $past(host_wr || cmd_wr))
		else $error("interrupt released without a clear");
	a_wr_one_clear: assert property (wr_flags && host_wdata[19:0] == 20'hFFFFF
		&& event_enable_reg == 20'h00000 |=> int_n)
		else $error("write of ones left a flag");
	a_wr_zero_keep: assert property (wr_flags && host_wdata[19:0] == 20'h00000 && !int_n
		|=> !int_n)
		else $error("write of zeros cleared a flag");
	a_rd_clears: assert property (rd_flags_cmd && !read_clear_inhibit
		&& event_enable_reg == 20'h00000 |=> int_n)
		else $error("read command did not clear flags");
	a_rd_inhibit: assert property (rd_flags_cmd && read_clear_inhibit && !int_n
		|=> !int_n [*2])
		else $error("inhibited read cleared flags");
	a_upper_zero: assert property (host_rvalid |-> host_rdata[31:24] == 8'h00)
		else $error("upper read bits not zero");
	a_flag_width: assert property (host_rvalid && $past(host_rd)
		&& $past(host_addr) == `AEF_ADDR_EVENT_FLAG |-> host_rdata[31:20] == 12'h000)
		else $error("undefined flag bits not zero");
	a_state_field: assert property (cmd_wr && cmd_code == `AEF_CMD_RD_EXT_STATE
		|=> host_rdata[4:0] == {$past(motion_sense_bit), $past(operating_state)})
		else $error("state or direction field wrong");
	a_depth_field: assert property (host_rd && host_addr == `AEF_ADDR_EXT_STATE
		|=> host_rdata[21:20] == $past(motion_queue_depth))
		else $error("motion queue depth field wrong");
endmodule
bind aef_flags_status aef_chk chk_u (.sys_clk, .rst_n, .host_addr, .host_rd, .host_wr,
	.host_wdata, .cmd_wr, .cmd_code, .host_rdata, .host_rvalid, .int_n, .event_enable_reg,
	.read_clear_inhibit, .stop_normal_evt, .operating_state, .motion_sense_bit,
	.motion_queue_depth);
`default_nettype wire

// ==== tb/axis_event_flags_and_status_bench.sv ====
// self-checking bench for the axis event flag and status block
`timescale 1ns/1ps
`default_nettype none
`include "aef_regs.vh"
module axis_event_flags_and_status_bench;
	logic	sys_clk = 1'b0, rst_n = 1'b0, go_pol = 1'b1, dir_pol = 1'b1, clr_pol = 1'b1;
	logic	ltc_pol = 1'b1, sd_pol = 1'b1, read_clear_inhibit, go_source_sel, ez_pol, erc_pol;
	logic	inp_pol, stop_normal_evt, prereg_shift_evt, motion_prereg_full, compare_prereg_full;
	logic	accelerating_flag, decelerating_flag, counter_cleared_evt, count_latched_evt;
	logic	motion_sense_bit, deviation_reset_output, slowdown_latch_release, local_go_input;
	logic	common_go_input_n, common_halt_input_n, common_emergency_input_n, encoder_index;
	logic	position_compare_pin, manual_direction_input_p, manual_direction_input_m;
	logic	counter_clear_input, latch_trigger, origin_sensor, slow_down_input_p;
	logic	slow_down_input_m, in_position_signal, pulser_enable_pin, pre;
	logic	host_rd, host_wr, cmd_wr, host_rvalid, int_n, err_read_clear;
	logic [1:0]		latch_timing_sel, compare_queue_depth, motion_queue_depth;
	logic [3:0]		clear_target_sel, operating_state;
	logic [4:0]		cmp_match;
	logic [7:0]		host_addr, cmd_code;
	logic [19:0]	event_enable_reg;
	logic [31:0]	host_wdata, cmd_wdata, host_rdata, q, r, want, seed = 32'h0000476A;
	int				model_flags, errors, checks_done;
	int				pin_bit [7] = '{13, 14, 15, 17, 19, 16, 18};

	aef_flags_status dut_u (.*);
	aef_host host_u (.*);
	always #5 sys_clk = ~sys_clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
		checks_done++;
		if (seen !== exp_v)
		begin
			errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp_v);
		end
	endtask
	task automatic results();
		$display("errors %0d, checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic flags_are(input int exp_f);
		host_u.xfer(0, `AEF_ADDR_EVENT_FLAG, 32'h0, q);
		check(q, exp_f);
		check({31'h0, int_n}, {31'h0, exp_f == 0});
	endtask
	// odd bits cleared alone directly, even ones by an all-ones command
	task automatic clear(input int k);
		if (k % 2)
			host_u.xfer(1, `AEF_ADDR_EVENT_FLAG, 1 << k, q);
		else
			host_u.xfer(2, `AEF_CMD_WR_EVENT_FLAG, 32'hFFFFFFFF, q);
		model_flags = 0;
		flags_are(model_flags);
	endtask
	task automatic set_src(input int k, input logic v);
		case (k)
			0: stop_normal_evt = v;
			1: prereg_shift_evt = v;
			2: motion_prereg_full = v;
			3: compare_prereg_full = v;
			4, 5: accelerating_flag = v;
			6, 7: decelerating_flag = v;
			default: cmp_match[k-8] = v;
		endcase
	endtask

	initial
	begin
		#100000;
		errors++;
		results();
	end
	initial
	begin
		{event_enable_reg, read_clear_inhibit, go_source_sel, latch_timing_sel, clear_target_sel,
			ez_pol, erc_pol, inp_pol, stop_normal_evt, prereg_shift_evt, motion_prereg_full,
			compare_prereg_full, accelerating_flag, decelerating_flag, cmp_match,
			counter_cleared_evt, count_latched_evt, operating_state, motion_sense_bit,
			deviation_reset_output, compare_queue_depth, motion_queue_depth,
			slowdown_latch_release, local_go_input, position_compare_pin, encoder_index,
			manual_direction_input_p, manual_direction_input_m, counter_clear_input,
			latch_trigger, origin_sensor, slow_down_input_p, slow_down_input_m,
			in_position_signal, pulser_enable_pin} = '0;
		{common_go_input_n, common_halt_input_n, common_emergency_input_n} = 3'h7;
		model_flags = 0;
		ticks(10);
		rst_n = 1'b1;
		ticks(4);
		host_u.xfer(0, 8'h44, 32'h0, q);
		check(q, 32'h0);
		flags_are(0);
		// engine sources: edge with mask bit off, then on
		for (int k = 0; k < 13; k++)
			for (int en = 0; en < 2; en++)
			begin
				pre = (k == 2 || k == 3 || k == 5 || k == 7);
				set_src(k, pre);
				ticks(2);
				r = xs();
				r[k] = en[0];
				event_enable_reg = r[19:0];
				set_src(k, !pre);
				ticks(1);
				event_enable_reg = 20'h00000;
				set_src(k, 1'b0);
				model_flags = en << k;
				flags_are(model_flags);
				clear(k);
			end
		// pin sources with the gating condition false, then true
		for (int j = 0; j < 7; j++)
			for (int g = 0; g < 2; g++)
			begin
				clear_target_sel = {3'h0, g[0]};
				latch_timing_sel = {1'b0, (j == 2) == g[0]};
				pulser_enable_pin = !g[0];
				motion_sense_bit = !g[0];
				go_source_sel = g[0];
				ticks(4);
				event_enable_reg = 20'h00001 << pin_bit[j];
				{counter_clear_input, latch_trigger, origin_sensor, manual_direction_input_p,
					local_go_input, slow_down_input_p, manual_direction_input_m} = 7'h40 >> j;
				ticks(4);
				counter_cleared_evt = (j == 0);
				count_latched_evt = (j == 1 || j == 2);
				ticks(1);
				{counter_cleared_evt, count_latched_evt, event_enable_reg} = 22'h0;
				{counter_clear_input, latch_trigger, origin_sensor, manual_direction_input_p,
					local_go_input, slow_down_input_p, manual_direction_input_m} = 7'h00;
				ticks(4);
				model_flags = g << pin_bit[j];
				flags_are(model_flags);
				clear(pin_bit[j]);
			end
		// read command keeps flags when inhibited, clears them otherwise
		for (int inh = 1; inh >= 0; inh--)
		begin
			read_clear_inhibit = inh[0];
			event_enable_reg = 20'h00101;
			stop_normal_evt = 1'b1;
			cmp_match[0] = 1'b1;
			ticks(1);
			{stop_normal_evt, cmp_match, event_enable_reg} = 26'h0;
			model_flags = 32'h00000101;
			host_u.xfer(2, `AEF_CMD_RD_EVENT_FLAG, 32'h0, q);
			check(q, model_flags);
			if (inh == 0)
				model_flags = 0;
			flags_are(model_flags);
			host_u.xfer(2, `AEF_CMD_RD_ERR_FLAG, 32'h0, q);
			check({31'h0, err_read_clear}, {31'h0, !inh[0]});
			for (int w = 0; w < 4 && inh == 1; w++)
			begin
				host_u.xfer(1, w == 2 ? `AEF_ADDR_EXT_STATE : `AEF_ADDR_EVENT_FLAG,
					w == 0 ? 32'h0 : w == 1 ? 32'hFFF00000 : 32'hFFFFFFFF, q);
				if (w == 3)
					model_flags = 0;
				flags_are(model_flags);
			end
		end
		// status fields from random levels; latched slow-down held, then released
		for (int i = 0; i < 6; i++)
		begin
			r = xs();
			{operating_state, motion_sense_bit, compare_queue_depth, motion_queue_depth} = r[8:0];
			{deviation_reset_output, erc_pol, ez_pol, encoder_index, inp_pol,
				in_position_signal} = r[14:9];
			{common_halt_input_n, common_emergency_input_n, position_compare_pin,
				manual_direction_input_p, manual_direction_input_m, counter_clear_input,
				latch_trigger, pulser_enable_pin} = r[22:15];
			{local_go_input, slow_down_input_p, slow_down_input_m, go_pol, dir_pol, clr_pol,
				ltc_pol} = r[29:23];
			// polarity held while the latches are not released, so no transient sticks
			sd_pol = i == 0 || r[30];
			slowdown_latch_release = (i != 0);
			ticks(4);
			want = {8'h00, slow_down_input_m ~^ sd_pol, i == 0 || (slow_down_input_p ~^ sd_pol),
				motion_queue_depth, compare_queue_depth, slow_down_input_m ~^ sd_pol,
				in_position_signal ~^ inp_pol, slow_down_input_p ~^ sd_pol,
				latch_trigger ~^ ltc_pol, counter_clear_input ~^ clr_pol,
				manual_direction_input_m ~^ dir_pol, manual_direction_input_p ~^ dir_pol,
				encoder_index ~^ ez_pol, deviation_reset_output ~^ erc_pol,
				position_compare_pin ~^ go_pol, !common_emergency_input_n, !common_halt_input_n,
				local_go_input ~^ go_pol, motion_sense_bit, operating_state};
			if (i % 2)
				host_u.xfer(2, `AEF_CMD_RD_EXT_STATE, 32'h0, q);
			else
				host_u.xfer(0, `AEF_ADDR_EXT_STATE, 32'h0, q);
			check(q, want);
		end
		// a pending flag is lost across a mid-run reset
		event_enable_reg = 20'h00001;
		stop_normal_evt = 1'b1;
		ticks(1);
		{stop_normal_evt, event_enable_reg} = 21'h0;
		flags_are(1);
		rst_n = 1'b0;
		ticks(10);
		rst_n = 1'b1;
		ticks(4);
		flags_are(0);
		results();
	end
endmodule
`default_nettype wire
